// [hw/divide_ratio_decode.sv]
// Purpose: Turn the raw output divide code into the ratio applied.
// Assumes: Code is the six-bit field of the divider register.
// Notes:   Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none

module divide_ratio_decode (
  input wire logic [5:0] code,
  output logic [5:0] ratio,
  output logic mute,
  output logic fundamental
);

  // ---------------------------------------------------------------
  // Ratio decode
  // ---------------------------------------------------------------
  // Odd codes above 1 lose their low bit, so 3 runs as 2 and 61 as 60.
  always_comb begin
    mute = (code == vco_cfg_pkg::DIV_MUTE); // R11
    fundamental = (code == vco_cfg_pkg::DIV_FUND); // R11
    if (code > vco_cfg_pkg::DIV_MAX) begin
      ratio = vco_cfg_pkg::DIV_MAX; // R12
    end else if (code <= vco_cfg_pkg::DIV_FUND) begin
      ratio = code; // R11
    end else begin
      ratio = {code[5:1], 1'b0}; // R12
    end
  end

endmodule : divide_ratio_decode

`default_nettype wire

// [hw/pll_aux_vco_divider_config.sv]
// Purpose: Configuration bank for the auxiliary pins, manual VCO
//          overrides and the output divider with its gains.
// Assumes: All inputs but RSTN are synchronous to CLK_SYS.
// Notes:   Every access costs one wait cycle on the Avalon port.
`timescale 1ns/1ps
`default_nettype none

module pll_aux_vco_divider_config #(
  parameter int SOURCE_COUNT = 32
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic [1:0] AVS_RESPONSE,
  output logic AVS_WAITREQUEST,
  input wire logic CHIP_EN,
  input wire logic EXACT_FREQ_MODE,
  input wire logic [SOURCE_COUNT-1:0] STATUS_SOURCES,
  input wire logic [2:0] AUX_SERIAL_OUT,
  input wire logic [2:0] AUX_SERIAL_OE,
  input wire logic AUTO_VTUNE_PRESET,
  input wire logic [2:0] AUTO_SUBBAND,
  input wire logic [4:0] AUTO_CAP_SETTING,
  output logic [2:0] AUX_OUT,
  output logic [2:0] AUX_OE,
  output logic AUX_PIN_LEVEL_SELECT,
  output logic PHASE_SYNC_TRIGGER,
  output logic GENERAL_STATUS_OUTPUT,
  output logic VCO_MANUAL_EN,
  output logic VTUNE_PRESET_EN,
  output logic [2:0] VCO_SUBBAND,
  output logic [4:0] VCO_CAP_SETTING,
  output logic CHARGE_PUMP_AUTOSCALE,
  output logic [5:0] DIVIDE_RATIO,
  output logic RF_MUTE,
  output logic FUNDAMENTAL_FREQUENCY,
  output logic [3:0] FIRST_RF_OUTPUT_ATTEN_DB,
  output logic [3:0] SECOND_RF_OUTPUT_ATTEN_DB,
  output logic [3:0] DIVIDER_STAGE_ATTEN_DB
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Maps a byte address onto a register; shared by read and write.
  function automatic vco_cfg_pkg::reg_sel_t decode(
    input logic [7:0] addr
  );
    vco_cfg_pkg::reg_sel_t sel;
    sel = vco_cfg_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[7:2])
        vco_cfg_pkg::AUX_PORT_IDX[5:0]: sel = vco_cfg_pkg::SEL_AUX;
        vco_cfg_pkg::MANUAL_VCO_IDX[5:0]: sel = vco_cfg_pkg::SEL_VCO;
        vco_cfg_pkg::OUT_DIV_IDX[5:0]: sel = vco_cfg_pkg::SEL_DIV;
        vco_cfg_pkg::STATUS_SEL_IDX[5:0]: sel = vco_cfg_pkg::SEL_STSEL;
        vco_cfg_pkg::BLOCK_STATUS_IDX[5:0]: sel = vco_cfg_pkg::SEL_STAT;
        default: sel = vco_cfg_pkg::SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode

  // Merges write data into a 24-bit register, one byte lane at a
  // time; lane 3 has no storage and is dropped.
  function automatic logic [23:0] merge(
    input logic [23:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [23:0] result;
    result = old;
    for (int i = 0; i < 3; i++) begin
      if (be[i]) begin
        result[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge

  // Gain code to attenuation below maximum, in 3 dB steps.
  function automatic logic [3:0] atten_db(input logic [1:0] code);
    logic [1:0] steps;
    steps = vco_cfg_pkg::GAIN_MAX_CODE - code;
    return 4'(steps * vco_cfg_pkg::GAIN_STEP_DB); // R13
  endfunction : atten_db

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  vco_cfg_pkg::bus_state_t state_reg;
  vco_cfg_pkg::reg_sel_t sel;
  logic [23:0] aux_reg;
  logic [23:0] vco_reg;
  logic [23:0] div_reg;
  logic [4:0] status_sel_reg;
  logic [31:0] readdata_reg;
  logic [1:0] response_reg;
  logic [31:0] read_next;
  logic write_now;
  logic chip_en_prev_reg;
  logic status_reg;
  logic [2:0] aux_out_reg;
  logic [2:0] aux_oe_reg;
  logic [2:0] aux_out_next;
  logic [2:0] aux_oe_next;
  logic [2:0] route_mask;
  logic [5:0] ratio_dec;
  logic mute_dec;
  logic fund_dec;
  logic [5:0] ratio_reg;
  logic mute_reg;
  logic fund_reg;
  logic level_reg;
  logic sync_reg;
  logic manual_reg;
  logic preset_reg;
  logic [2:0] band_reg;
  logic [4:0] cap_reg;
  logic cpscale_reg;
  logic [3:0] atten1_reg;
  logic [3:0] atten2_reg;
  logic [3:0] atten_div_reg;
  vco_cfg_pkg::disabled_pins_t dis_mode;
  logic [1:0] route_code;

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------

  // Each request is held off for exactly one cycle. The answer is
  // prepared in that cycle so read data come straight from a flop.
  assign sel = decode(AVS_ADDRESS);
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) &
                           (state_reg == vco_cfg_pkg::BUS_IDLE);
  assign write_now = AVS_WRITE & (state_reg == vco_cfg_pkg::BUS_ANSWER);
  assign AVS_READDATA = readdata_reg;
  assign AVS_RESPONSE = response_reg;

  // The slave walks IDLE to ANSWER and back for every request.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= vco_cfg_pkg::BUS_IDLE;
    end else begin
      unique case (state_reg)
        vco_cfg_pkg::BUS_IDLE: begin
          if (AVS_READ | AVS_WRITE) begin
            state_reg <= vco_cfg_pkg::BUS_ANSWER;
          end
        end
        vco_cfg_pkg::BUS_ANSWER: begin
          state_reg <= vco_cfg_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Read mux; narrower registers sit in the low bits, rest is zero.
  always_comb begin
    read_next = 32'h00000000;
    unique case (sel)
      vco_cfg_pkg::SEL_AUX: read_next = {8'h00, aux_reg};
      vco_cfg_pkg::SEL_VCO: read_next = {8'h00, vco_reg};
      vco_cfg_pkg::SEL_DIV: read_next = {8'h00, div_reg};
      vco_cfg_pkg::SEL_STSEL: read_next = {27'h0000000, status_sel_reg};
      vco_cfg_pkg::SEL_STAT: read_next = {22'h000000, CHIP_EN,
                                          status_reg, fund_reg,
                                          mute_reg, ratio_reg};
      default: read_next = 32'h00000000;
    endcase
  end

  // Answer is latched on the waiting cycle and stands through the
  // answer cycle. Unmapped addresses answer SLVERR.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      readdata_reg <= 32'h00000000;
      response_reg <= vco_cfg_pkg::RESP_OKAY;
    end else if (state_reg == vco_cfg_pkg::BUS_IDLE &&
                 (AVS_READ | AVS_WRITE)) begin
      readdata_reg <= AVS_READ ? read_next : 32'h00000000;
      response_reg <= (sel == vco_cfg_pkg::SEL_NONE) ?
                      vco_cfg_pkg::RESP_SLVERR : vco_cfg_pkg::RESP_OKAY;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------

  // Reserved bits store whatever is written, so software that keeps
  // them at their reset values sees them unchanged on read-back.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      aux_reg <= vco_cfg_pkg::AUX_PORT_RST;
      vco_reg <= vco_cfg_pkg::MANUAL_VCO_RST;
      div_reg <= vco_cfg_pkg::OUT_DIV_RST;
      status_sel_reg <= vco_cfg_pkg::STATUS_SEL_RST;
    end else if (write_now) begin
      if (sel == vco_cfg_pkg::SEL_AUX) begin
        aux_reg <= merge(aux_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (sel == vco_cfg_pkg::SEL_VCO) begin
        vco_reg <= merge(vco_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (sel == vco_cfg_pkg::SEL_DIV) begin
        div_reg <= merge(div_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (sel == vco_cfg_pkg::SEL_STSEL && AVS_BYTEENABLE[0]) begin
        status_sel_reg <= AVS_WRITEDATA[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Routed status and phase sync
  // ---------------------------------------------------------------

  // Select values beyond the source count read as low.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      status_reg <= 1'b0;
    end else if (32'(status_sel_reg) < SOURCE_COUNT) begin
      status_reg <= STATUS_SOURCES[status_sel_reg]; // R15
    end else begin
      status_reg <= 1'b0;
    end
  end

  // A rising edge on the enable pin fires one sync pulse, but only
  // in exact frequency mode; elsewhere the phase is not defined.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      chip_en_prev_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      chip_en_prev_reg <= CHIP_EN;
      sync_reg <= aux_reg[vco_cfg_pkg::AUX_SYNC_BIT] & EXACT_FREQ_MODE &
                  CHIP_EN & ~chip_en_prev_reg; // R04
    end
  end

  // ---------------------------------------------------------------
  // Auxiliary pins
  // ---------------------------------------------------------------
  assign route_code = aux_reg[vco_cfg_pkg::AUX_ROUTE_LSB +: 2];
  assign dis_mode = vco_cfg_pkg::disabled_pins_t'(
                      aux_reg[vco_cfg_pkg::AUX_DIS_LSB +: 2]);

  // One-hot mask of the pin that carries the routed status.
  generate
    for (genvar p = 0; p < 3; p++) begin : g_route
      assign route_mask[p] = (route_code == 2'(p + 1)); // R05
    end
  endgenerate

  // Pin drive: serial engine or static values, the routed status on
  // top, and the disabled-chip policy over everything.
  always_comb begin
    if (aux_reg[vco_cfg_pkg::AUX_MODE_BIT]) begin
      aux_out_next = AUX_SERIAL_OUT; // R01
      aux_oe_next = AUX_SERIAL_OE; // R01
    end else begin
      aux_out_next = aux_reg[vco_cfg_pkg::AUX_VAL_LSB +: 3]; // R02
      aux_oe_next = 3'h7; // R01
    end
    aux_out_next = (aux_out_next & ~route_mask) |
                   ({3{status_reg}} & route_mask); // R05
    aux_oe_next = aux_oe_next | route_mask; // R05
    if (!CHIP_EN) begin
      unique case (dis_mode)
        vco_cfg_pkg::DIS_HIZ: begin
          aux_out_next = 3'h0; // R06
          aux_oe_next = 3'h0; // R06
        end
        vco_cfg_pkg::DIS_HOLD: begin
          aux_out_next = aux_out_reg; // R06
          aux_oe_next = aux_oe_reg; // R06
        end
        vco_cfg_pkg::DIS_HIGH: begin
          aux_out_next = 3'h7; // R06
          aux_oe_next = 3'h7; // R06
        end
        vco_cfg_pkg::DIS_LOW: begin
          aux_out_next = 3'h0; // R06
          aux_oe_next = 3'h7; // R06
        end
      endcase
    end
  end

  // Pins change one cycle after their cause, two after a routed status source, never glitching.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      aux_out_reg <= 3'h0;
      aux_oe_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      aux_out_reg <= aux_out_next;
      aux_oe_reg <= aux_oe_next;
      level_reg <= aux_reg[vco_cfg_pkg::AUX_LEVEL_BIT]; // R03
    end
  end

  // ---------------------------------------------------------------
  // Manual VCO overrides
  // ---------------------------------------------------------------

  // With manual tuning off, bits 8..0 are ignored entirely and the
  // calibration machine's values pass through unchanged.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      manual_reg <= 1'b0;
      preset_reg <= 1'b0;
      band_reg <= 3'h0;
      cap_reg <= 5'h00;
      cpscale_reg <= 1'b0;
    end else begin
      manual_reg <= vco_reg[vco_cfg_pkg::VCO_MANUAL_BIT]; // R08
      cpscale_reg <= vco_reg[vco_cfg_pkg::VCO_CPSCALE_BIT]; // R10
      if (vco_reg[vco_cfg_pkg::VCO_MANUAL_BIT]) begin
        preset_reg <= vco_reg[vco_cfg_pkg::VCO_PRESET_BIT]; // R07
        band_reg <= vco_reg[vco_cfg_pkg::VCO_BAND_LSB +: 3]; // R09
        cap_reg <= vco_reg[vco_cfg_pkg::VCO_CAP_LSB +: 5]; // R09
      end else begin
        preset_reg <= AUTO_VTUNE_PRESET; // R08
        band_reg <= AUTO_SUBBAND; // R08
        cap_reg <= AUTO_CAP_SETTING; // R08
      end
    end
  end

  // ---------------------------------------------------------------
  // Output divider and gains
  // ---------------------------------------------------------------
  divide_ratio_decode u_divide (
    .code(div_reg[vco_cfg_pkg::DIV_CODE_LSB +: 6]),
    .ratio(ratio_dec),
    .mute(mute_dec),
    .fundamental(fund_dec)
  );

  // Decoded ratio and attenuations are registered for clean outputs.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ratio_reg <= 6'h00;
      mute_reg <= 1'b0;
      fund_reg <= 1'b0;
      atten1_reg <= 4'h0;
      atten2_reg <= 4'h0;
      atten_div_reg <= 4'h0;
    end else begin
      ratio_reg <= ratio_dec; // R12
      mute_reg <= mute_dec; // R11
      fund_reg <= fund_dec; // R11
      atten1_reg <= atten_db(div_reg[vco_cfg_pkg::GAIN1_LSB +: 2]); // R13
      atten2_reg <= atten_db(div_reg[vco_cfg_pkg::GAIN2_LSB +: 2]); // R13
      atten_div_reg <= div_reg[vco_cfg_pkg::DIV_GAIN_BIT] ?
                       4'h0 : vco_cfg_pkg::GAIN_STEP_DB; // R14
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign AUX_OUT = aux_out_reg;
  assign AUX_OE = aux_oe_reg;
  assign AUX_PIN_LEVEL_SELECT = level_reg;
  assign PHASE_SYNC_TRIGGER = sync_reg;
  assign GENERAL_STATUS_OUTPUT = status_reg;
  assign VCO_MANUAL_EN = manual_reg;
  assign VTUNE_PRESET_EN = preset_reg;
  assign VCO_SUBBAND = band_reg;
  assign VCO_CAP_SETTING = cap_reg;
  assign CHARGE_PUMP_AUTOSCALE = cpscale_reg;
  assign DIVIDE_RATIO = ratio_reg;
  assign RF_MUTE = mute_reg;
  assign FUNDAMENTAL_FREQUENCY = fund_reg;
  assign FIRST_RF_OUTPUT_ATTEN_DB = atten1_reg;
  assign SECOND_RF_OUTPUT_ATTEN_DB = atten2_reg;
  assign DIVIDER_STAGE_ATTEN_DB = atten_div_reg;

endmodule : pll_aux_vco_divider_config

`default_nettype wire

// [hw/vco_cfg_pkg.sv]
// Purpose: Shared constants for the auxiliary port, manual VCO and
//          output divider configuration bank.
// Assumes: Registers are reached over Avalon-MM, 32-bit data.
// Notes:   Register byte address is four times the register index.
//
// How it works
// R01 - Mode bit picks serial port or static outputs
// R02 - Three static values drive the three pins
// R03 - Level bit selects 1.8 V or 3.3 V high
// R04 - Enable pin edge triggers phase sync
// R05 - Route field sends status to one pin
// R06 - Disabled-chip field sets pin drive behaviour
// R07 - Preset bit enables manual tune-voltage preset
// R08 - Manual bit hands tuning to bits 8..0
// R09 - Sub-band and capacitor fields under manual tuning
// R10 - Auto-scale bit scales charge pump current
// R11 - Divide code: mute, fundamental, even ratios
// R12 - Odd codes round down, above 62 clamp
// R13 - Gain codes give 0/3/6/9 dB below maximum
// R14 - Divider stage gain max or 3 dB down
// R15 - Five-bit select picks the routed status
// R16 - Software keeps reserved fields at reset values

package vco_cfg_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int REG_W = 24;
  localparam int ADDR_W = 8;
  localparam logic [7:0] AUX_PORT_IDX = 8'h14;
  localparam logic [7:0] MANUAL_VCO_IDX = 8'h15;
  localparam logic [7:0] OUT_DIV_IDX = 8'h16;
  localparam logic [7:0] STATUS_SEL_IDX = 8'h1F;
  localparam logic [7:0] BLOCK_STATUS_IDX = 8'h20;
  localparam logic [23:0] AUX_PORT_RST = 24'h000220;
  localparam logic [23:0] MANUAL_VCO_RST = 24'h0F48A0;
  localparam logic [23:0] OUT_DIV_RST = 24'h0006C1;
  localparam logic [4:0] STATUS_SEL_RST = 5'h01;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AUX_MODE_BIT = 0;
  localparam int AUX_VAL_LSB = 1;
  localparam int AUX_LEVEL_BIT = 4;
  localparam int AUX_SYNC_BIT = 9;
  localparam int AUX_ROUTE_LSB = 10;
  localparam int AUX_DIS_LSB = 12;
  localparam int VCO_PRESET_BIT = 0;
  localparam int VCO_CAP_LSB = 1;
  localparam int VCO_BAND_LSB = 6;
  localparam int VCO_MANUAL_BIT = 9;
  localparam int VCO_CPSCALE_BIT = 16;
  localparam int DIV_CODE_LSB = 0;
  localparam int GAIN1_LSB = 6;
  localparam int GAIN2_LSB = 8;
  localparam int DIV_GAIN_BIT = 10;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [5:0] DIV_MUTE = 6'h00;
  localparam logic [5:0] DIV_FUND = 6'h01;
  localparam logic [5:0] DIV_MAX = 6'h3E;
  localparam logic [3:0] GAIN_STEP_DB = 4'h3;
  localparam logic [1:0] GAIN_MAX_CODE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DIS_HIZ = 2'b00,
    DIS_HOLD = 2'b01,
    DIS_HIGH = 2'b10,
    DIS_LOW = 2'b11
  } disabled_pins_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

  typedef enum logic [2:0] {
    SEL_AUX = 3'b000,
    SEL_VCO = 3'b001,
    SEL_DIV = 3'b010,
    SEL_STSEL = 3'b011,
    SEL_STAT = 3'b100,
    SEL_NONE = 3'b111
  } reg_sel_t;

endpackage : vco_cfg_pkg

// [tb/pll_aux_vco_divider_config_sva.sv]
// Purpose: Port checks for the configuration bank.
// Assumes: One clock, CLK_SYS; RSTN async active low.
// Notes:   Bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module pll_aux_vco_divider_config_chk (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic [31:0] AVS_READDATA,
  input wire logic CHIP_EN,
  input wire logic EXACT_FREQ_MODE,
  input wire logic PHASE_SYNC_TRIGGER,
  input wire logic [5:0] DIVIDE_RATIO,
  input wire logic RF_MUTE,
  input wire logic FUNDAMENTAL_FREQUENCY,
  input wire logic [3:0] FIRST_RF_OUTPUT_ATTEN_DB,
  input wire logic [3:0] DIVIDER_STAGE_ATTEN_DB,
  input wire logic VCO_MANUAL_EN,
  input wire logic [2:0] VCO_SUBBAND,
  input wire logic [2:0] AUTO_SUBBAND
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // All checks run on CLK_SYS and sleep in reset.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // Each request has one wait cycle.
  sequence req_start;
    (AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE);
  endsequence
  sequence one_wait;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence

  chk_bus_wait: assert property (req_start |-> one_wait)
    else $error("wait cycle count wrong");
  chk_read_hold: assert property (AVS_READ && !AVS_WAITREQUEST |=>
    $stable(AVS_READDATA)) else $error("read data moved");
  chk_ratio_even: assert property ((!DIVIDE_RATIO[0] ||
    DIVIDE_RATIO == 6'h01) && DIVIDE_RATIO <= 6'h3E)
    else $error("bad divide ratio");
  // Reset zeros are not judged.
  chk_mute_code: assert property ($past(RSTN) |->
    RF_MUTE == (DIVIDE_RATIO == 6'h00) &&
    FUNDAMENTAL_FREQUENCY == (DIVIDE_RATIO == 6'h01))
    else $error("mute or fund flag wrong");
  chk_gain_step: assert property (FIRST_RF_OUTPUT_ATTEN_DB inside
    {4'h0, 4'h3, 4'h6, 4'h9}) else $error("gain step not 3 dB");
  chk_stage_gain: assert property (DIVIDER_STAGE_ATTEN_DB inside
    {4'h0, 4'h3}) else $error("stage gain out of set");
  chk_sync_cause: assert property (PHASE_SYNC_TRIGGER |->
    $past(CHIP_EN) && !$past(CHIP_EN, 2) && $past(EXACT_FREQ_MODE))
    else $error("phase sync without enable rise");
  chk_sync_pulse: assert property ($rose(PHASE_SYNC_TRIGGER) |=>
    !PHASE_SYNC_TRIGGER) else $error("phase sync pulse too long");
  chk_auto_tune: assert property (!VCO_MANUAL_EN |->
    VCO_SUBBAND == $past(AUTO_SUBBAND))
    else $error("sub-band not auto");
endmodule : pll_aux_vco_divider_config_chk

bind pll_aux_vco_divider_config pll_aux_vco_divider_config_chk u_chk (
  .CLK_SYS, .RSTN, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .AVS_READDATA,
  .CHIP_EN, .EXACT_FREQ_MODE, .PHASE_SYNC_TRIGGER, .DIVIDE_RATIO, .RF_MUTE,
  .FUNDAMENTAL_FREQUENCY, .FIRST_RF_OUTPUT_ATTEN_DB, .DIVIDER_STAGE_ATTEN_DB,
  .VCO_MANUAL_EN, .VCO_SUBBAND, .AUTO_SUBBAND);

`default_nettype wire

// [tb/pll_aux_vco_divider_config_tb_top.sv]
// Purpose: Bench for the configuration bank.
// Assumes: Outputs settle within 3 edges.
// Notes:   Reserved fields keep reset values.
`timescale 1ns/1ps
`default_nettype none

module pll_aux_vco_divider_config_tb_top;
  logic CLK_SYS = 1'b0;
  logic RSTN, AVS_READ, AVS_WRITE, CHIP_EN, EXACT_FREQ_MODE;
  logic AUTO_VTUNE_PRESET, AVS_WAITREQUEST, AUX_PIN_LEVEL_SELECT;
  logic PHASE_SYNC_TRIGGER, GENERAL_STATUS_OUTPUT, VCO_MANUAL_EN;
  logic VTUNE_PRESET_EN, CHARGE_PUMP_AUTOSCALE, RF_MUTE;
  logic FUNDAMENTAL_FREQUENCY;
  logic [7:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, STATUS_SOURCES, q, v;
  logic [3:0] AVS_BYTEENABLE, FIRST_RF_OUTPUT_ATTEN_DB;
  logic [3:0] SECOND_RF_OUTPUT_ATTEN_DB, DIVIDER_STAGE_ATTEN_DB;
  logic [1:0] AVS_RESPONSE, r;
  logic [2:0] AUX_SERIAL_OUT, AUX_SERIAL_OE, AUTO_SUBBAND, AUX_OUT, AUX_OE;
  logic [2:0] VCO_SUBBAND, exp_out, exp_oe;
  logic [4:0] AUTO_CAP_SETTING, VCO_CAP_SETTING, sel;
  logic [5:0] DIVIDE_RATIO;
  logic [23:0] mdl [3];
  int bad_count = 0;
  int num_checks = 0;
  int seed = 32'hA450A110;
  int i, n;

  pll_aux_vco_divider_config u_dut (.CLK_SYS, .RSTN, .AVS_ADDRESS,
    .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
    .AVS_RESPONSE, .AVS_WAITREQUEST, .CHIP_EN, .EXACT_FREQ_MODE,
    .STATUS_SOURCES, .AUX_SERIAL_OUT, .AUX_SERIAL_OE, .AUTO_VTUNE_PRESET,
    .AUTO_SUBBAND, .AUTO_CAP_SETTING, .AUX_OUT, .AUX_OE,
    .AUX_PIN_LEVEL_SELECT, .PHASE_SYNC_TRIGGER, .GENERAL_STATUS_OUTPUT,
    .VCO_MANUAL_EN, .VTUNE_PRESET_EN, .VCO_SUBBAND, .VCO_CAP_SETTING,
    .CHARGE_PUMP_AUTOSCALE, .DIVIDE_RATIO, .RF_MUTE, .FUNDAMENTAL_FREQUENCY,
    .FIRST_RF_OUTPUT_ATTEN_DB, .SECOND_RF_OUTPUT_ATTEN_DB,
    .DIVIDER_STAGE_ATTEN_DB);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // 10 MHz system clock.
  always #50 CLK_SYS = ~CLK_SYS;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // One access, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    #1;
    while (AVS_WAITREQUEST !== 1'b0 && k < 50) begin
      @(posedge CLK_SYS);
      #1;
      k++;
    end
    if (k >= 50) chk(32'h0, 32'h1, "no bus answer");
    @(posedge CLK_SYS);
    q = AVS_READDATA;
    r = AVS_RESPONSE;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (w && a[1:0] == 2'h0 && a >= 8'h50 && a <= 8'h58) begin
      mdl[(a - 8'h50) >> 2] = d[23:0];
    end
  endtask : bus

  // Pins lag a change by at most two edges.
  task automatic settle;
    repeat (3) @(posedge CLK_SYS);
    #1;
  endtask : settle

  function automatic logic [5:0] div_exp(input logic [5:0] c);
    if (c > 6'h3E) return 6'h3E;
    if (c > 6'h01) return {c[5:1], 1'b0};
    return c;
  endfunction : div_exp

  function automatic logic [3:0] att(input logic [1:0] g);
    return 4'h9 - 4'h3 * {2'h0, g};
  endfunction : att

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset, divider, VCO, aux pins, refused accesses.
  initial begin
    {RSTN, AVS_READ, AVS_WRITE, CHIP_EN, EXACT_FREQ_MODE} = 5'h00;
    {AUTO_VTUNE_PRESET, AUTO_SUBBAND, AUTO_CAP_SETTING} = 9'h000;
    {AUX_SERIAL_OUT, AUX_SERIAL_OE} = 6'h00;
    {AVS_ADDRESS, AVS_WRITEDATA} = 40'h0;
    AVS_BYTEENABLE = 4'hF;
    STATUS_SOURCES = 32'h0;
    mdl = '{24'h000220, 24'h0F48A0, 24'h0006C1};
    repeat (8) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    settle;
    chk(DIVIDE_RATIO, 1, "reset ratio");
    chk(SECOND_RF_OUTPUT_ATTEN_DB, 3, "reset gain2");
    chk(CHARGE_PUMP_AUTOSCALE, 1, "reset autoscale");
    for (i = 0; i < 3; i++) begin
      bus(1'b0, 8'h50 + 8'(4 * i), 32'h0);
      chk(q, {8'h00, mdl[i]}, "reset value");
      chk(r, 2'h0, "reset resp");
    end
    for (i = 0; i < 64; i++) begin
      v = $random(seed);
      bus(1'b1, 8'h58, {21'h0, v[10:6], 6'(i)});
      settle;
      chk(DIVIDE_RATIO, div_exp(6'(i)), "ratio");
      chk(RF_MUTE, i == 0, "mute");
      chk(FUNDAMENTAL_FREQUENCY, i == 1, "fund");
      chk(FIRST_RF_OUTPUT_ATTEN_DB, att(v[7:6]), "gain1");
      chk(SECOND_RF_OUTPUT_ATTEN_DB, att(v[9:8]), "gain2");
      chk(DIVIDER_STAGE_ATTEN_DB, v[10] ? 0 : 3, "stage");
    end
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[9] = i[0];
      @(posedge CLK_SYS);
      {AUTO_VTUNE_PRESET, AUTO_CAP_SETTING, AUTO_SUBBAND} <= v[29:21];
      bus(1'b1, 8'h54, 32'h0E4800 | (v & 32'h103FF));
      settle;
      chk(VCO_MANUAL_EN, v[9], "manual");
      chk(VCO_SUBBAND, v[9] ? v[8:6] : v[23:21], "band");
      chk(VCO_CAP_SETTING, v[9] ? v[5:1] : v[28:24], "cap");
      chk(VTUNE_PRESET_EN, v[9] ? v[0] : v[29], "preset");
      chk(CHARGE_PUMP_AUTOSCALE, v[16], "autoscale");
    end
    sel = 5'($random(seed));
    bus(1'b1, 8'h7C, {27'h0, sel});
    for (i = 0; i < 32; i++) begin
      v = $random(seed);
      v[13:10] = i[3:0];
      v[0] = i[4];
      @(posedge CLK_SYS);
      STATUS_SOURCES <= $random(seed);
      {EXACT_FREQ_MODE, AUX_SERIAL_OE, AUX_SERIAL_OUT} <= v[20:14];
      bus(1'b1, 8'h50, (v & 32'h3E1F) | 32'h20);
      @(posedge CLK_SYS);
      CHIP_EN <= 1'b1;
      n = 0;
      repeat (4) begin
        @(posedge CLK_SYS);
        #1;
        n += PHASE_SYNC_TRIGGER;
      end
      chk(n, v[9] & v[20], "sync pulses");
      settle;
      // Mode picks the source; a routed status claims its pin.
      exp_out = v[0] ? v[16:14] : v[3:1];
      exp_oe = v[0] ? v[19:17] : 3'h7;
      if (v[11:10] != 2'h0) begin
        exp_out[v[11:10] - 2'h1] = STATUS_SOURCES[sel];
        exp_oe[v[11:10] - 2'h1] = 1'b1;
      end
      chk(GENERAL_STATUS_OUTPUT, STATUS_SOURCES[sel], "status");
      chk(AUX_OUT, exp_out, "aux out");
      chk(AUX_OE, exp_oe, "aux oe");
      chk(AUX_PIN_LEVEL_SELECT, v[4], "level");
      @(posedge CLK_SYS);
      CHIP_EN <= 1'b0;
      settle;
      if (v[13:12] != 2'h1) begin
        exp_out = {3{v[13:12] == 2'h2}};
        exp_oe = {3{v[13]}};
      end
      chk(AUX_OUT, exp_out, "off out");
      chk(AUX_OE, exp_oe, "off oe");
    end
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0, "unmapped data");
    chk(r, 2'h2, "unmapped resp");
    bus(1'b1, 8'h59, 32'hFFFFFF);
    chk(r, 2'h2, "misaligned resp");
    bus(1'b0, 8'h58, 32'h0);
    chk(q, {8'h00, mdl[2]}, "register kept");
    stop_test;
  end

  // Watchdog; the run needs about a thousand cycles.
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    chk(32'h0, 32'h1, "watchdog");
    stop_test;
  end
endmodule : pll_aux_vco_divider_config_tb_top

`default_nettype wire
